// File: aisc_pkg.sv
// Constants for the analog input select control block.
// Assumes an 8-bit special-function-register bus on page 0.
package aisc_pkg;
  // ----------------------------------------
  // Register offsets and resets
  // ----------------------------------------
  localparam logic [7:0] AISC_ADDR_CHANNEL_SELECT = 8'hBB;
  localparam logic [7:0] AISC_ADDR_PAIR_CONFIG = 8'hBA;
  localparam logic [7:0] AISC_ADDR_PIN_ENABLE = 8'hBD;
  localparam logic [7:0] AISC_ADDR_AMP_CONTROL = 8'hD6;
  localparam logic [7:0] AISC_SFR_PAGE = 8'h00;
  localparam logic [7:0] AISC_RESET_VALUE = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AISC_AMP_ENABLE_BIT = 7;
  localparam int AISC_GAIN_LSB = 0;
  localparam int AISC_GAIN_WIDTH = 4;
  localparam int AISC_PAIR01_BIT = 0;
  localparam int AISC_PAIR23_BIT = 1;
  localparam int AISC_AMP_PAIR_BIT = 2;
  localparam int AISC_PORT_PAIR_BIT = 3;
  // ----------------------------------------
  // Source selection codes (one-hot)
  // ----------------------------------------
  typedef enum logic [8:0] {
    AISC_SRC_EXT0 = 9'h001,
    AISC_SRC_EXT1 = 9'h002,
    AISC_SRC_EXT2 = 9'h004,
    AISC_SRC_EXT3 = 9'h008,
    AISC_SRC_AMP = 9'h010,
    AISC_SRC_GROUND = 9'h020,
    AISC_SRC_EVEN = 9'h040,
    AISC_SRC_ODD = 9'h080,
    AISC_SRC_TEMP = 9'h100
  } aisc_src_t;
  // Negative side selection
  typedef enum logic [4:0] {
    AISC_NEG_GROUND = 5'h01,
    AISC_NEG_EXT1 = 5'h02,
    AISC_NEG_EXT3 = 5'h04,
    AISC_NEG_REF = 5'h08,
    AISC_NEG_ODD = 5'h10
  } aisc_neg_t;
endpackage : aisc_pkg

// File: aisc_reg_if.sv
// Carries one register write strobe and data between top and storage.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface aisc_reg_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  modport owner (input wr_en, input wr_data, output value);
  modport user (output wr_en, output wr_data, input value);
endinterface : aisc_reg_if
`default_nettype wire

// File: aisc_reg8.sv
// One 8-bit register with a mask of writable bits.
// Assumes synchronous write strobe, asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module aisc_reg8 #(
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  input wire logic clock,
  input wire logic resetn,
  aisc_reg_if.owner port
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Unwritable bits hold their reset zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      port.value <= aisc_pkg::AISC_RESET_VALUE;
    end else if (port.wr_en) begin
      port.value <= port.wr_data & WRITE_MASK;
    end
  end
endmodule // aisc_reg8
`default_nettype wire

// File: aisc_analog_input_select_ctrl.sv
// Analog input select control: registers and source decode.
// Assumes an 8-bit SFR bus, page select given, sync to clock.
// Summary of operation
// - Channel select upper nibble reads zero
// - Decode all sixteen channel codes
// - Single-ended channel code to source map
// - Even and odd port groups, pairable
// - Pin enable bit routes port pin
// - Any pin combination, same parity wired-OR
// - Amplifier positive; reference negative when paired
// - Control bit 7 enables amplifier
// - Four-bit gain code selects amplifier gain
// - Pair bits make inputs differential
// - Differential results flagged two's complement
`timescale 1ns/1ns
`default_nettype none
module aisc_analog_input_select_ctrl (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [8:0] pos_select,
  output logic [4:0] neg_select,
  output logic differential,
  output logic twos_complement,
  output logic [7:0] even_port_group,
  output logic [7:0] odd_port_group,
  output logic high_voltage_amp_enable,
  output logic [3:0] high_voltage_gain_code
);
  // ----------------------------------------
  // Register instances
  // ----------------------------------------
  aisc_reg_if sel_if ();
  aisc_reg_if cfg_if ();
  aisc_reg_if prt_if ();
  aisc_reg_if amp_if ();
  logic on_page;
  assign on_page = (sfr_page == aisc_pkg::AISC_SFR_PAGE);
  // Write strobes per register
  assign sel_if.wr_en = sfr_wr && on_page && (sfr_addr == aisc_pkg::AISC_ADDR_CHANNEL_SELECT);
  assign cfg_if.wr_en = sfr_wr && on_page && (sfr_addr == aisc_pkg::AISC_ADDR_PAIR_CONFIG);
  assign prt_if.wr_en = sfr_wr && on_page && (sfr_addr == aisc_pkg::AISC_ADDR_PIN_ENABLE);
  assign amp_if.wr_en = sfr_wr && on_page && (sfr_addr == aisc_pkg::AISC_ADDR_AMP_CONTROL);
  assign sel_if.wr_data = sfr_wdata;
  assign cfg_if.wr_data = sfr_wdata;
  assign prt_if.wr_data = sfr_wdata;
  assign amp_if.wr_data = sfr_wdata;
  // Upper nibble masked so it reads zero
  aisc_reg8 #(.WRITE_MASK(8'h0F)) u_input_channel_select (
    .clock(clock),
    .resetn(resetn),
    .port(sel_if.owner)
  );
  aisc_reg8 #(.WRITE_MASK(8'h0F)) u_pair_configuration_reg (
    .clock(clock),
    .resetn(resetn),
    .port(cfg_if.owner)
  );
  aisc_reg8 #(.WRITE_MASK(8'hFF)) u_port_pin_analog_enable (
    .clock(clock),
    .resetn(resetn),
    .port(prt_if.owner)
  );
  // Reserved bits 6-4 kept zero; gain takes bits 3-0
  aisc_reg8 #(.WRITE_MASK(8'h8F)) u_high_voltage_amp_control (
    .clock(clock),
    .resetn(resetn),
    .port(amp_if.owner)
  );
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Registered read data; unmapped addresses return zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= aisc_pkg::AISC_RESET_VALUE;
    end else if (sfr_rd) begin
      if (!on_page) begin
        sfr_rdata <= 8'h00;
      end else begin
        case (sfr_addr)
          aisc_pkg::AISC_ADDR_CHANNEL_SELECT: sfr_rdata <= sel_if.value;
          aisc_pkg::AISC_ADDR_PAIR_CONFIG: sfr_rdata <= cfg_if.value;
          aisc_pkg::AISC_ADDR_PIN_ENABLE: sfr_rdata <= prt_if.value;
          aisc_pkg::AISC_ADDR_AMP_CONTROL: sfr_rdata <= amp_if.value;
          default: sfr_rdata <= 8'h00;
        endcase
      end
    end
  end
  // Address hit, combinational
  always_comb begin
    sfr_hit = on_page && ((sfr_addr == aisc_pkg::AISC_ADDR_CHANNEL_SELECT)
      || (sfr_addr == aisc_pkg::AISC_ADDR_PAIR_CONFIG)
      || (sfr_addr == aisc_pkg::AISC_ADDR_PIN_ENABLE)
      || (sfr_addr == aisc_pkg::AISC_ADDR_AMP_CONTROL));
  end
  // ----------------------------------------
  // Source decode
  // ----------------------------------------
  logic [3:0] channel_code;
  logic pair01_config_bit;
  logic pair23_config_bit;
  logic amp_pair_config_bit;
  logic port_group_pair_config_bit;
  aisc_pkg::aisc_src_t next_pos;
  aisc_pkg::aisc_neg_t next_neg;
  logic next_diff;
  assign channel_code = sel_if.value[3:0];
  assign pair01_config_bit = cfg_if.value[aisc_pkg::AISC_PAIR01_BIT];
  assign pair23_config_bit = cfg_if.value[aisc_pkg::AISC_PAIR23_BIT];
  assign amp_pair_config_bit = cfg_if.value[aisc_pkg::AISC_AMP_PAIR_BIT];
  assign port_group_pair_config_bit = cfg_if.value[aisc_pkg::AISC_PORT_PAIR_BIT];
  // Paired odd member codes alias to the pair (+even, -odd; amplifier pair takes reference negative)
  always_comb begin
    next_pos = aisc_pkg::AISC_SRC_TEMP;
    next_neg = aisc_pkg::AISC_NEG_GROUND;
    next_diff = 1'b0;
    case (channel_code[3])
      1'b1: next_pos = aisc_pkg::AISC_SRC_TEMP;
      default: begin
        case (channel_code[2:0])
          3'h0, 3'h1: begin
            if (pair01_config_bit) begin
              next_pos = aisc_pkg::AISC_SRC_EXT0;
              next_neg = aisc_pkg::AISC_NEG_EXT1;
              next_diff = 1'b1;
            end else begin
              if (channel_code[0]) begin
                next_pos = aisc_pkg::AISC_SRC_EXT1;
              end else begin
                next_pos = aisc_pkg::AISC_SRC_EXT0;
              end
            end
          end
          3'h2, 3'h3: begin
            if (pair23_config_bit) begin
              next_pos = aisc_pkg::AISC_SRC_EXT2;
              next_neg = aisc_pkg::AISC_NEG_EXT3;
              next_diff = 1'b1;
            end else begin
              if (channel_code[0]) begin
                next_pos = aisc_pkg::AISC_SRC_EXT3;
              end else begin
                next_pos = aisc_pkg::AISC_SRC_EXT2;
              end
            end
          end
          3'h4, 3'h5: begin
            if (amp_pair_config_bit) begin
              next_pos = aisc_pkg::AISC_SRC_AMP;
              next_neg = aisc_pkg::AISC_NEG_REF;
              next_diff = 1'b1;
            end else begin
              if (channel_code[0]) begin
                next_pos = aisc_pkg::AISC_SRC_GROUND;
              end else begin
                next_pos = aisc_pkg::AISC_SRC_AMP;
              end
            end
          end
          default: begin
            if (port_group_pair_config_bit) begin
              next_pos = aisc_pkg::AISC_SRC_EVEN;
              next_neg = aisc_pkg::AISC_NEG_ODD;
              next_diff = 1'b1;
            end else begin
              if (channel_code[0]) begin
                next_pos = aisc_pkg::AISC_SRC_ODD;
              end else begin
                next_pos = aisc_pkg::AISC_SRC_EVEN;
              end
            end
          end
        endcase
      end
    endcase
  end
  // Selection outputs registered so the front end sees clean levels
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pos_select <= aisc_pkg::AISC_SRC_EXT0;
      neg_select <= aisc_pkg::AISC_NEG_GROUND;
      differential <= 1'b0;
      twos_complement <= 1'b0;
    end else begin
      pos_select <= next_pos;
      neg_select <= next_neg;
      differential <= next_diff;
      twos_complement <= next_diff;
    end
  end
  // ----------------------------------------
  // Port group switches
  // ----------------------------------------
  // Per-pin switch into its parity bus; analog side shorts same-parity pins
  genvar pin;
  generate
    for (pin = 0; pin < 8; pin++) begin : g_pin
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          even_port_group[pin] <= 1'b0;
          odd_port_group[pin] <= 1'b0;
        end else begin
          even_port_group[pin] <= prt_if.value[pin] && (pin % 2 == 0);
          odd_port_group[pin] <= prt_if.value[pin] && (pin % 2 == 1);
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Amplifier control
  // ----------------------------------------
  // Enable and gain registered; reserved bits never reach the front end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      high_voltage_amp_enable <= 1'b0;
      high_voltage_gain_code <= 4'h0;
    end else begin
      high_voltage_amp_enable <= amp_if.value[aisc_pkg::AISC_AMP_ENABLE_BIT];
      high_voltage_gain_code <= amp_if.value[aisc_pkg::AISC_GAIN_LSB +: aisc_pkg::AISC_GAIN_WIDTH];
    end
  end
endmodule // aisc_analog_input_select_ctrl
`default_nettype wire

// File: aisc_chk.sv
// Port assertions for the analog input select control block.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module aisc_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic [8:0] pos_select,
  input wire logic [4:0] neg_select,
  input wire logic differential,
  input wire logic twos_complement,
  input wire logic [7:0] even_port_group,
  input wire logic [7:0] odd_port_group,
  input wire logic high_voltage_amp_enable,
  input wire logic [3:0] high_voltage_gain_code
);
  // ------------------------------
  // Port relations
  // ------------------------------
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Reads and decode shape
  AST_UPPER_ZERO: assert property (sfr_rd && sfr_page == 8'h00 && sfr_addr == 8'hBB |=> sfr_rdata[7:4] == 4'h0)
    else $error("channel select upper bits not zero");
  AST_ONE_HOT: assert property ($onehot(pos_select) && $onehot(neg_select))
    else $error("source select not one-hot");
  AST_TEMP_SINGLE: assert property (pos_select == 9'h100 |-> neg_select == 5'h01 && !differential)
    else $error("temperature source not single-ended");
  AST_AMP_REF: assert property (pos_select == 9'h010 && differential |-> neg_select == 5'h08)
    else $error("amplifier pair lacks reference");
  AST_DIFF_NEG: assert property (differential == (neg_select != 5'h01))
    else $error("pair flag and negative side disagree");
  AST_TWOS: assert property (twos_complement == differential)
    else $error("result format flag wrong");
  // Writes reach the outputs two edges later; no other write lands between
  AST_PIN_ROUTE: assert property (sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'hBD |-> ##2
    even_port_group == ($past(sfr_wdata, 2) & 8'h55) && odd_port_group == ($past(sfr_wdata, 2) & 8'hAA))
    else $error("port groups do not follow pin enables");
  AST_AMP_ENABLE: assert property (sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'hD6 |-> ##2
    high_voltage_amp_enable == $past(sfr_wdata[7], 2))
    else $error("amplifier enable wrong");
  AST_AMP_GAIN: assert property (sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'hD6 |-> ##2
    high_voltage_gain_code == $past(sfr_wdata[3:0], 2))
    else $error("gain code wrong");
  AST_HOLD: assert property (!sfr_wr ##1 !sfr_wr |=> $stable(pos_select) && $stable(neg_select))
    else $error("selection moved without a write");
endmodule // aisc_chk
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the analog input select control block.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ------------------------------
  // Stimulus, model and checks
  // ------------------------------
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_rdata, even_port_group, odd_port_group;
  logic sfr_hit, differential, twos_complement, high_voltage_amp_enable;
  logic [8:0] pos_select;
  logic [4:0] neg_select;
  logic [3:0] high_voltage_gain_code;
  int failures = 0, checked = 0;
  logic [7:0] mreg [256];
  logic [7:0] addrs [5] = '{8'hBA, 8'hBB, 8'hBD, 8'hD6, 8'hBC};
  aisc_analog_input_select_ctrl uut (.clock, .resetn, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .pos_select, .neg_select, .differential, .twos_complement, .even_port_group,
    .odd_port_group, .high_voltage_amp_enable, .high_voltage_gain_code);
  // Free-running 20 MHz clock
  initial begin
    forever #25 clock = ~clock;
  end
  // Counts every compare; case inequality so an unknown output fails
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // Writable bits per register; zero marks an unmapped place
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'hBA, 8'hBB: return 8'h0F;
      8'hBD: return 8'hFF;
      8'hD6: return 8'h8F;
      default: return 8'h00;
    endcase
  endfunction
  // Expected outputs from the model registers; odd codes of a pair fold onto it
  task automatic outs();
    logic [3:0] c;
    logic [1:0] p;
    logic pr;
    c = mreg[8'hBB][3:0];
    p = c[2:1];
    pr = mreg[8'hBA][p] && !c[3];
    check(pos_select, c[3] ? 9'h100 : pr ? 9'h001 << (2 * p) : 9'h001 << c[2:0]);
    check(neg_select, pr ? 5'h02 << p : 5'h01);
    check(differential, pr);
    check(twos_complement, pr);
    check(even_port_group, mreg[8'hBD] & 8'h55);
    check(odd_port_group, mreg[8'hBD] & 8'hAA);
    check(high_voltage_amp_enable, mreg[8'hD6][7]);
    check(high_voltage_gain_code, mreg[8'hD6][3:0]);
  endtask
  // One bus cycle, write or read, then an idle edge so outputs settle
  task automatic put(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d, input logic w);
    sfr_page = p;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    #1;
    check(sfr_hit, p == 8'h00 && mask_of(a) != 8'h00);
    @(posedge clock);
    #1;
    if (w) begin
      if (p == 8'h00) mreg[a] = d & mask_of(a);
    end else check(sfr_rdata, p == 8'h00 ? mreg[a] : 8'h00);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(posedge clock);
    #1;
    outs();
  endtask
  // Reset is asynchronous; outputs are checked while it is still held
  task automatic do_reset();
    resetn = 1'b0;
    foreach (mreg[i]) mreg[i] = 8'h00;
    repeat (10) @(posedge clock);
    #1;
    outs();
    check(sfr_rdata, 8'h00);
    resetn = 1'b1;
  endtask
  // Single verdict point for the main sequence and the watchdog
  task automatic stop_test();
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence: reset values, full code sweep, random traffic, mid-run reset
  initial begin
    void'($urandom(61824));
    do_reset();
    for (int a = 0; a < 5; a++) put(8'h00, addrs[a], 8'h00, 1'b0);
    for (int f = 0; f < 16; f++) begin
      put(8'h00, 8'hBA, 8'(f), 1'b1);
      for (int c = 0; c < 16; c++) put(8'h00, 8'hBB, 8'($urandom) & 8'hF0 | 8'(c), 1'b1);
    end
    for (int i = 0; i < 400; i++) begin
      put($urandom_range(3) == 0 ? 8'($urandom) : 8'h00, $urandom_range(5) == 5 ? 8'($urandom) :
        addrs[$urandom_range(4)], 8'($urandom), 1'($urandom));
    end
    do_reset();
    put(8'h00, 8'hD6, 8'hFF, 1'b1);
    put(8'h00, 8'hD6, 8'h00, 1'b0);
    stop_test();
  end
  // Watchdog well past the expected run of about 1400 cycles
  initial begin
    #(50 * 8000);
    failures++;
    stop_test();
  end
endmodule // testbench
bind aisc_analog_input_select_ctrl aisc_chk chk (.clock, .resetn, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .sfr_hit, .pos_select, .neg_select, .differential, .twos_complement, .even_port_group,
  .odd_port_group, .high_voltage_amp_enable, .high_voltage_gain_code);
`default_nettype wire
